// ### core/scss_pkg.sv
// Package of constants and types for the sample clock sync and status block
package scss_pkg;

  // Clock rate in kHz and documented times
  localparam int CLOCK_KHZ = 250000;
  localparam int HOLD_TIME_MS = 3;
  // Cycles for the knob hold that selects the expansion host link
  localparam int HOLD_CYCLES = HOLD_TIME_MS * CLOCK_KHZ;
  // Flash period in cycles (half period), roughly 4 Hz blink
  localparam int FLASH_HALF_MS = 125;
  localparam int FLASH_CYCLES = FLASH_HALF_MS * CLOCK_KHZ;
  // Word-clock high-rate multiplier
  localparam int HIGH_RATE_MULT = 256;

  // Reset values
  localparam logic [2:0] RESET_RATE = 3'h0;

  // Sync sources
  typedef enum logic [1:0] {
    SCSS_SRC_LOCAL,
    SCSS_SRC_WORDCLOCK,
    SCSS_SRC_DIGITAL,
    SCSS_SRC_OPTICAL
  } scss_source_t;

  // Rate converter placement
  typedef enum logic [1:0] {
    SCSS_CONV_OFF,
    SCSS_CONV_INPUT,
    SCSS_CONV_OUTPUT
  } scss_conv_t;

  // Word-clock output modes
  typedef enum logic [1:0] {
    SCSS_WCK_RATE,
    SCSS_WCK_HIGH,
    SCSS_WCK_BASE
  } scss_wck_t;

  // Rate codes: bit 0 clear is 44.1 kHz family, set is 48 kHz family
  localparam logic [2:0] RATE_44K1 = 3'h0;
  localparam logic [2:0] RATE_48K = 3'h1;

endpackage

// ### core/scss_settings_mem.sv
// Small settings store that stands in front of the non-volatile flash
`timescale 1ns/1ps
module scss_settings_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic write_en,
  input wire logic [15:0] write_data,
  output logic [15:0] read_data,
  output logic valid
);
  // Held settings word and its valid flag; the flag starts as blank flash
  logic [15:0] store;
  logic store_valid = 1'b0;
  logic [15:0] next_store;
  logic next_store_valid;
  logic [15:0] next_read_data;

  // Next values: write replaces the word, read data is registered
  // No write while held in reset, so a glitch on entry cannot save junk
  always_comb begin
    next_store = store;
    next_store_valid = store_valid;
    if (write_en && !rst) begin
      next_store = write_data;
      next_store_valid = 1'b1;
    end
    next_read_data = store;
  end

  // Register stage; word and flag survive rst like the flash they model
  always_ff @(posedge clock) begin
    store <= next_store;
    store_valid <= next_store_valid;
    read_data <= next_read_data;
  end

  // Registered valid copy; not reset, so the power-up check can see it
  always_ff @(posedge clock) begin
    valid <= store_valid;
  end
endmodule

// ### core/scss_sample_clock_sync_status.sv
// Sample clock source selection, word-clock mode and front-panel status
`timescale 1ns/1ps
module scss_sample_clock_sync_status (
  input wire logic clock,
  input wire logic rst,
  input wire scss_pkg::scss_source_t sync_select,
  input wire logic [2:0] chosen_rate,
  input wire logic optical_mode_en,
  input wire scss_pkg::scss_conv_t rate_converter,
  input wire logic [2:0] converter_out_rate,
  input wire scss_pkg::scss_wck_t wck_mode,
  input wire logic [3:0] ext_valid,
  input wire logic [2:0] ext_rate_wck,
  input wire logic [2:0] ext_rate_dig,
  input wire logic [2:0] ext_rate_opt,
  input wire logic meter_output_mode,
  input wire logic [7:0] limiter_active,
  input wire logic [7:0] host_out_error,
  input wire logic digital_carrier,
  input wire logic [1:0] digital_out_error,
  input wire logic expansion_fitted,
  input wire logic usb_present,
  input wire logic identify,
  input wire logic standby_req,
  input wire logic knob_down,
  input wire logic [15:0] control_settings,
  output logic [15:0] restored_settings,
  output logic settings_restored,
  output logic stand_alone,
  output scss_pkg::scss_source_t active_source,
  output logic [2:0] sample_rate,
  output logic [2:0] output_rate,
  output logic clock_master,
  output logic master_indicator,
  output scss_pkg::scss_wck_t wck_out_mode,
  output logic [2:0] wck_out_rate,
  output logic [8:0] wck_multiplier,
  output logic [7:0] limiter_indicator,
  output logic input_unlock_indicator,
  output logic converter_indicator,
  output logic meter_input_indicator,
  output logic meter_output_indicator,
  output logic host_green,
  output logic host_red,
  output logic standby_indicator,
  output logic audio_enable,
  output logic in_standby,
  output logic mute_assigned,
  output logic ring_flash
);
  import scss_pkg::*;

  // All checks below sample on the one clock and pause in reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Shared flash timebase
  logic [26:0] flash_count;
  logic flash_phase;
  logic [26:0] next_flash_count;
  logic next_flash_phase;
  // Knob hold counter and press edge
  logic [31:0] hold_count;
  logic [31:0] next_hold_count;
  logic knob_prev;
  logic hold_done;
  logic next_hold_done;
  // Host link and mute
  logic expansion_host;
  logic next_expansion_host;
  logic muted;
  logic next_muted;
  // Standby, power-up restore
  logic standby;
  logic next_standby;
  logic boot_done;
  logic next_boot_done;
  logic next_stand_alone;
  logic mem_write;
  logic [15:0] mem_rdata;
  logic mem_valid;
  // Sync decisions
  scss_source_t next_active_source;
  logic [2:0] next_sample_rate;
  logic fallback;
  logic next_fallback;
  logic [2:0] sel_rate;
  logic sel_valid;
  logic sel_offered;

  // Non-volatile settings copy, written on standby entry
  scss_settings_mem settings_mem (
    .clock(clock),
    .rst(rst),
    .write_en(mem_write),
    .write_data(control_settings),
    .read_data(mem_rdata),
    .valid(mem_valid)
  );

  // Rate family check shared by word-clock base mode
  function automatic logic [2:0] base_rate(input logic [2:0] rate);
    base_rate = rate[0] ? RATE_48K : RATE_44K1;
  endfunction

  // Flash timebase: one toggle every half period
  always_comb begin
    next_flash_count = flash_count + 27'h1;
    next_flash_phase = flash_phase;
    if (flash_count == 27'(FLASH_CYCLES - 1)) begin
      next_flash_count = 27'h0;
      next_flash_phase = ~flash_phase;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flash_count <= 27'h0;
      flash_phase <= 1'b0;
    end else begin
      flash_count <= next_flash_count;
      flash_phase <= next_flash_phase;
    end
  end

  // Selected source view; optical only counts in optical mode
  always_comb begin
    sel_offered = 1'b1;
    sel_rate = chosen_rate;
    sel_valid = 1'b0;
    case (sync_select)
      SCSS_SRC_WORDCLOCK: begin
        sel_rate = ext_rate_wck;
        sel_valid = ext_valid[1];
      end
      SCSS_SRC_DIGITAL: begin
        sel_rate = ext_rate_dig;
        sel_valid = ext_valid[2];
      end
      SCSS_SRC_OPTICAL: begin
        sel_offered = optical_mode_en;
        sel_rate = ext_rate_opt;
        sel_valid = ext_valid[3] & optical_mode_en;
      end
      default: begin
        sel_offered = 1'b1;
      end
    endcase
  end

  // Sync decision; sync_select is only read, never rewritten
  always_comb begin
    next_active_source = SCSS_SRC_LOCAL;
    next_sample_rate = chosen_rate;
    next_fallback = 1'b0;
    if (sync_select != SCSS_SRC_LOCAL) begin
      if (sel_valid && sel_offered &&
          (stand_alone || sel_rate == chosen_rate)) begin
        next_active_source = sync_select;
        if (stand_alone) begin
          next_sample_rate = sel_rate;
        end
      end else begin
        next_fallback = 1'b1;
      end
    end
  end

  // Common rate for all channels; converter output has its own
  always_ff @(posedge clock) begin
    if (rst) begin
      active_source <= SCSS_SRC_LOCAL;
      sample_rate <= RESET_RATE;
      fallback <= 1'b0;
      output_rate <= RESET_RATE;
      clock_master <= 1'b1;
      master_indicator <= 1'b1;
      audio_enable <= 1'b0;
    end else begin
      active_source <= next_active_source;
      sample_rate <= next_sample_rate;
      fallback <= next_fallback;
      output_rate <= (rate_converter == SCSS_CONV_OUTPUT) ?
        converter_out_rate : next_sample_rate;
      clock_master <= next_active_source == SCSS_SRC_LOCAL;
      // Lit as master, off as slave, flashing on fallback
      master_indicator <= next_fallback ? flash_phase :
        (next_active_source == SCSS_SRC_LOCAL);
      audio_enable <= ~standby;
    end
  end

  // Word-clock output mode and rate
  always_ff @(posedge clock) begin
    if (rst) begin
      wck_out_mode <= SCSS_WCK_RATE;
      wck_out_rate <= RESET_RATE;
      wck_multiplier <= 9'h1;
    end else begin
      wck_out_mode <= wck_mode;
      case (wck_mode)
        SCSS_WCK_HIGH: begin
          wck_out_rate <= sample_rate;
          wck_multiplier <= 9'(HIGH_RATE_MULT);
        end
        SCSS_WCK_BASE: begin
          wck_out_rate <= base_rate(sample_rate);
          wck_multiplier <= 9'h1;
        end
        default: begin
          wck_out_rate <= sample_rate;
          wck_multiplier <= 9'h1;
        end
      endcase
    end
  end

  // Meter panel indicators
  always_ff @(posedge clock) begin
    if (rst) begin
      limiter_indicator <= 8'h00;
      input_unlock_indicator <= 1'b0;
      converter_indicator <= 1'b0;
      meter_input_indicator <= 1'b1;
      meter_output_indicator <= 1'b0;
    end else begin
      meter_input_indicator <= ~meter_output_mode;
      meter_output_indicator <= meter_output_mode;
      if (meter_output_mode) begin
        limiter_indicator <= host_out_error;
        input_unlock_indicator <= |digital_out_error;
        converter_indicator <=
          rate_converter == SCSS_CONV_OUTPUT;
      end else begin
        limiter_indicator <= limiter_active;
        input_unlock_indicator <= ~digital_carrier;
        converter_indicator <=
          rate_converter == SCSS_CONV_INPUT;
      end
    end
  end

  // Knob: press toggles mute, a 3 ms hold picks the expansion link
  always_comb begin
    next_hold_count = hold_count;
    next_hold_done = hold_done;
    next_muted = muted;
    next_expansion_host = expansion_host & expansion_fitted;
    if (knob_down) begin
      if (!knob_prev) begin
        next_muted = ~muted;
      end
      if (hold_count < 32'(HOLD_CYCLES)) begin
        next_hold_count = hold_count + 32'h1;
      end else if (!hold_done && expansion_fitted) begin
        next_hold_done = 1'b1;
        next_expansion_host = 1'b1;
      end
    end else begin
      next_hold_count = 32'h0;
      next_hold_done = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hold_count <= 32'h0;
      hold_done <= 1'b0;
      muted <= 1'b0;
      expansion_host <= 1'b0;
      knob_prev <= 1'b0;
      mute_assigned <= 1'b0;
      ring_flash <= 1'b0;
      host_green <= 1'b1;
      host_red <= 1'b0;
    end else begin
      hold_count <= next_hold_count;
      hold_done <= next_hold_done;
      muted <= next_muted;
      expansion_host <= next_expansion_host;
      knob_prev <= knob_down;
      mute_assigned <= next_muted;
      ring_flash <= next_muted & flash_phase;
      host_green <= ~next_expansion_host;
      host_red <= next_expansion_host;
    end
  end

  // Standby entry saves settings; boot restores when no USB
  always_comb begin
    next_standby = standby_req;
    next_boot_done = 1'b1;
    next_stand_alone = stand_alone;
    mem_write = standby_req & ~standby;
    if (!boot_done) begin
      next_stand_alone = ~usb_present & mem_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      standby <= 1'b0;
      boot_done <= 1'b0;
      stand_alone <= 1'b0;
      in_standby <= 1'b0;
      standby_indicator <= 1'b0;
      settings_restored <= 1'b0;
      restored_settings <= 16'h0000;
    end else begin
      standby <= next_standby;
      boot_done <= next_boot_done;
      stand_alone <= next_stand_alone;
      in_standby <= next_standby;
      standby_indicator <= identify & flash_phase;
      if (!boot_done && next_stand_alone) begin
        settings_restored <= 1'b1;
        restored_settings <= mem_rdata;
      end
    end
  end

  // Master indicator off whenever slaved to a source
  a_slave_lamp_off: assert property (
    ##1 (!clock_master && !$past(next_fallback)) |-> !master_indicator)
    else $error("master lamp lit while slaved");
  a_master_lamp_lit: assert property (
    ##1 ($past(sync_select) == SCSS_SRC_LOCAL) |->
    (clock_master && master_indicator))
    else $error("local mode lamp not lit");
  a_fallback_local: assert property (
    next_fallback |=> (active_source == SCSS_SRC_LOCAL &&
    sample_rate == $past(chosen_rate)))
    else $error("fallback not on local rate");
  a_optical_gate: assert property (
    !optical_mode_en |=> active_source != SCSS_SRC_OPTICAL)
    else $error("optical used while disabled");
  a_high_mult: assert property (
    wck_mode == SCSS_WCK_HIGH |=> wck_multiplier == 9'h100)
    else $error("high-rate multiplier wrong");
  a_base_family: assert property (
    wck_mode == SCSS_WCK_BASE |=> wck_out_rate[0] == $past(sample_rate[0]))
    else $error("base clock family wrong");
  a_limiter_in: assert property (
    !meter_output_mode |=> limiter_indicator == $past(limiter_active))
    else $error("limiter lamp mismatch");
  a_unlock_out: assert property (
    meter_output_mode |=> input_unlock_indicator == |$past(digital_out_error))
    else $error("unlock lamp mismatch");
  a_host_lamp: assert property (
    host_green != host_red)
    else $error("host lamp both or neither");
  a_identify_off: assert property (
    !identify |=> !standby_indicator)
    else $error("standby lamp flashing w/o identify");
  // Stand-alone lock takes the measured rate of the source
  a_sa_follow: assert property (
    stand_alone && next_active_source != SCSS_SRC_LOCAL |=>
    sample_rate == $past(sel_rate))
    else $error("stand-alone rate not followed");
  // Every press flips the mute state once
  a_mute_toggle: assert property (
    knob_down && !knob_prev |=> mute_assigned != $past(mute_assigned))
    else $error("knob press did not toggle mute");
  // Power-up with a saved word and no USB restores it
  a_restore_boot: assert property (
    !boot_done && !usb_present && mem_valid |=>
    (stand_alone && settings_restored &&
    restored_settings == $past(mem_rdata)))
    else $error("settings not restored at power-up");
endmodule

// ### tb/scss_sync_source_model.sv
// Model of the external word-clock, digital and optical sync sources
`timescale 1ns/1ps
module scss_sync_source_model (
  input wire logic clock,
  input wire logic [3:0] present,
  input wire logic [8:0] rates,
  output logic [3:0] ext_valid,
  output logic [2:0] ext_rate_wck,
  output logic [2:0] ext_rate_dig,
  output logic [2:0] ext_rate_opt,
  output logic digital_carrier
);
  // Pattern for an unplugged source, so no stale rate can look valid
  logic [2:0] junk = 3'h5;
  always @(posedge clock) begin
    junk <= junk + 3'h3;
  end
  // A missing source shows no valid flag and a wandering rate
  always_comb begin
    ext_valid = {present[3:1], 1'b0};
    ext_rate_wck = present[1] ? rates[2:0] : junk;
    ext_rate_dig = present[2] ? rates[5:3] : junk;
    ext_rate_opt = present[3] ? rates[8:6] : junk;
    digital_carrier = present[2];
  end
endmodule

// ### tb/sample_clock_sync_status_test.sv
// Self-checking bench for the sample clock sync and status block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED at %0t got %0h exp %0h", $time, g, e); end end
module sample_clock_sync_status_test;
  import scss_pkg::*;
  logic clock = 0;
  logic rst = 1;
  scss_source_t sync_select = SCSS_SRC_LOCAL;
  logic [2:0] chosen_rate = 3'h0;
  logic optical_mode_en = 0;
  scss_conv_t rate_converter = SCSS_CONV_OFF;
  logic [2:0] converter_out_rate = 3'h0;
  scss_wck_t wck_mode = SCSS_WCK_RATE;
  logic [3:0] present = 4'h0;
  logic [8:0] rates = 9'h000;
  logic meter_output_mode = 0;
  logic [7:0] limiter_active = 8'h00;
  logic [7:0] host_out_error = 8'h00;
  logic [1:0] digital_out_error = 2'h0;
  logic expansion_fitted = 0, usb_present = 1, identify = 0;
  logic standby_req = 0, knob_down = 0;
  logic [15:0] control_settings = 16'h0000;
  logic [3:0] ext_valid;
  logic [2:0] ext_rate_wck, ext_rate_dig, ext_rate_opt;
  logic digital_carrier;
  logic [15:0] restored_settings;
  logic settings_restored, stand_alone, clock_master, master_indicator;
  scss_source_t active_source;
  scss_wck_t wck_out_mode;
  logic [2:0] sample_rate, output_rate, wck_out_rate;
  logic [8:0] wck_multiplier;
  logic [7:0] limiter_indicator;
  logic input_unlock_indicator, converter_indicator, meter_input_indicator;
  logic meter_output_indicator, host_green, host_red, standby_indicator;
  logic audio_enable, in_standby, mute_assigned, ring_flash;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;
  bit exp_mute = 0;
  bit exp_sa = 0;

  // Free-running 250 MHz clock
  initial begin
    forever #2 clock = ~clock;
  end

  scss_sync_source_model u_scss_sync_source_model (.clock(clock),
    .present(present), .rates(rates), .ext_valid(ext_valid),
    .ext_rate_wck(ext_rate_wck), .ext_rate_dig(ext_rate_dig),
    .ext_rate_opt(ext_rate_opt), .digital_carrier(digital_carrier));

  scss_sample_clock_sync_status u_scss_sample_clock_sync_status (
    .clock(clock), .rst(rst), .sync_select(sync_select),
    .chosen_rate(chosen_rate), .optical_mode_en(optical_mode_en),
    .rate_converter(rate_converter), .converter_out_rate(converter_out_rate),
    .wck_mode(wck_mode), .ext_valid(ext_valid), .ext_rate_wck(ext_rate_wck),
    .ext_rate_dig(ext_rate_dig), .ext_rate_opt(ext_rate_opt),
    .meter_output_mode(meter_output_mode), .limiter_active(limiter_active),
    .host_out_error(host_out_error), .digital_carrier(digital_carrier),
    .digital_out_error(digital_out_error),
    .expansion_fitted(expansion_fitted), .usb_present(usb_present),
    .identify(identify), .standby_req(standby_req), .knob_down(knob_down),
    .control_settings(control_settings),
    .restored_settings(restored_settings),
    .settings_restored(settings_restored), .stand_alone(stand_alone),
    .active_source(active_source), .sample_rate(sample_rate),
    .output_rate(output_rate), .clock_master(clock_master),
    .master_indicator(master_indicator), .wck_out_mode(wck_out_mode),
    .wck_out_rate(wck_out_rate), .wck_multiplier(wck_multiplier),
    .limiter_indicator(limiter_indicator),
    .input_unlock_indicator(input_unlock_indicator),
    .converter_indicator(converter_indicator),
    .meter_input_indicator(meter_input_indicator),
    .meter_output_indicator(meter_output_indicator),
    .host_green(host_green), .host_red(host_red),
    .standby_indicator(standby_indicator), .audio_enable(audio_enable),
    .in_standby(in_standby), .mute_assigned(mute_assigned),
    .ring_flash(ring_flash));

  // Prints the counts and the verdict, then stops the run
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Guard against a hang; the whole run needs well under 2000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  // Lets every latency land, then compares against the reference model.
  // Flash phase stays 0 this early, so a fallback shows an unlit lamp.
  task automatic settle_check();
    int sel;
    bit lock;
    bit om;
    logic [2:0] er;
    logic [2:0] exp_rate;
    repeat (4) @(posedge clock);
    @(negedge clock);
    sel = int'(sync_select);
    om = meter_output_mode;
    er = sel == 1 ? rates[2:0] : sel == 2 ? rates[5:3] : rates[8:6];
    lock = sel != 0 && present[sel] && (exp_sa || er == chosen_rate) &&
           (sel != 3 || optical_mode_en);
    exp_rate = (lock && exp_sa) ? er : chosen_rate;
    `CHK(active_source, lock ? sync_select : SCSS_SRC_LOCAL)
    `CHK(clock_master, !lock)
    `CHK(master_indicator, sel == 0)
    `CHK(sample_rate, exp_rate)
    `CHK(output_rate, rate_converter == SCSS_CONV_OUTPUT ?
         converter_out_rate : exp_rate)
    `CHK(wck_out_mode, wck_mode)
    `CHK(wck_multiplier, wck_mode == SCSS_WCK_HIGH ? 9'h100 : 9'h001)
    `CHK(wck_out_rate, wck_mode == SCSS_WCK_BASE ?
         {2'h0, exp_rate[0]} : exp_rate)
    `CHK(limiter_indicator, om ? host_out_error : limiter_active)
    `CHK(input_unlock_indicator, om ? |digital_out_error : !present[2])
    `CHK(converter_indicator, rate_converter ==
         (om ? SCSS_CONV_OUTPUT : SCSS_CONV_INPUT))
    `CHK({meter_input_indicator, meter_output_indicator}, {!om, om})
    `CHK({host_green, host_red}, 2'h2)
    `CHK(mute_assigned, exp_mute)
    `CHK({in_standby, audio_enable}, {standby_req, !standby_req})
    `CHK({ring_flash, standby_indicator}, 2'h0)
    `CHK({stand_alone, settings_restored}, {exp_sa, exp_sa})
  endtask

  // Main sequence
  initial begin
    logic [2:0] r;
    logic [15:0] w, saved;
    void'($urandom(32'h83868512));
    repeat (3) @(posedge clock);
    rst <= 0;
    settle_check();
    $display("test reset done");
    // Every source, optical mode on and off, matching and wrong rates
    for (int i = 0; i < 48; i++) begin
      r = 3'($urandom);
      @(posedge clock);
      sync_select <= scss_source_t'(i % 4);
      optical_mode_en <= i[2];
      present <= {3'($urandom), 1'b0};
      chosen_rate <= r;
      rates <= i[3] ? {r, r, r} : 9'($urandom);
      wck_mode <= scss_wck_t'(i % 3);
      rate_converter <= scss_conv_t'($urandom_range(0, 2));
      converter_out_rate <= 3'($urandom);
      meter_output_mode <= i[4];
      limiter_active <= 8'($urandom);
      host_out_error <= 8'($urandom);
      digital_out_error <= 2'($urandom);
      settle_check();
    end
    $display("test sources done");
    // Lock, lose the source, then see it return at the right rate
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      sync_select <= SCSS_SRC_DIGITAL;
      rates <= {3{chosen_rate}};
      present <= k == 1 ? 4'h0 : 4'h4;
      settle_check();
    end
    $display("test recovery done");
    // Knob presses back to back; a short hold must not switch the host
    @(posedge clock);
    expansion_fitted <= 1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      knob_down <= 1;
      @(posedge clock);
      knob_down <= 0;
      exp_mute = !exp_mute;
      settle_check();
    end
    $display("test knob done");
    // Standby entry and exit with a fresh settings word, identify latched
    for (int k = 0; k < 2; k++) begin
      w = 16'($urandom);
      @(posedge clock);
      standby_req <= !k[0];
      control_settings <= w;
      identify <= 1;
      if (!k[0]) begin
        saved = w;
      end
      settle_check();
    end
    $display("test standby done");
    // Power-up without USB: saved word returns, rate follows the source
    @(posedge clock);
    usb_present <= 0;
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    exp_mute = 0;
    exp_sa = 1;
    settle_check();
    `CHK(restored_settings, saved)
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      rates <= {3{3'(chosen_rate + 3'h1)}};
      present <= k == 0 ? 4'h4 : 4'h0;
      settle_check();
    end
    $display("test stand-alone done");
    finish_test();
  end
endmodule
